// ---- verilog/brcr_regs.svh ----
// Bit positions, reset value and decode constants of the read configuration register
`ifndef BRCR_REGS_SVH
`define BRCR_REGS_SVH

`define BRCR_READ_TYPE_BIT 15
`define BRCR_AUTO_SLEEP_BIT 14
`define BRCR_DELAY_MSB 13
`define BRCR_DELAY_LSB 10
`define BRCR_DATA_HOLD_BIT 9
`define BRCR_END_TIMING_BIT 8
`define BRCR_BURST_ORDER_BIT 7
`define BRCR_CLOCK_EDGE_BIT 6
`define BRCR_RESET_VALUE 16'h9cc4
`define BRCR_DELAY_BASE 4'h2
`define BRCR_DELAY_MAX_CODE 4'h7
`define BRCR_UPPER_ZERO 16'h0000

`endif

// ---- verilog/brcr_pkg.sv ----
// Types shared by the read configuration register block
package brcr_pkg;

    typedef struct packed {
        logic read_type_select;
        logic auto_sleep_off;
        logic [3:0] initial_delay_field;
        logic data_hold_config;
        logic end_indicator_timing;
        logic burst_order_select;
        logic clock_edge_select;
        logic [5:0] low_bits;
    } brcr_cfg_t;

    typedef struct packed {
        logic sync_burst_en;
        logic auto_sleep_en;
        logic [3:0] initial_delay_clks;
        logic [1:0] data_hold_clks;
        logic end_early;
        logic linear_order;
        logic rising_edge;
    } brcr_ctrl_t;

endpackage : brcr_pkg

// ---- verilog/brcr_config.sv ----
// Read configuration register with its decoded burst controls
`timescale 1ns/1ps
`include "brcr_regs.svh"

// What this block does
// - Top bit zero selects synchronous burst reads; one selects asynchronous, the default.
// - Auto-sleep disable bit zero keeps automatic sleep on; one turns it off.
// - Delay codes 0000 to 0111 give 2 to 9 clocks; default 0111.
// - Data hold zero holds each word one clock; one is reserved.
// - End timing zero asserts indicator during delay; one asserts a cycle earlier.
// - Burst order one means linear order, the default; zero reserved.
// - Clock edge one starts bursts and drives data on rising edges.
// - Writes during an active program or erase are ignored; reads always allowed.
// - Register read shows sixteen bits low, zeroes on the upper sixteen lines.
// - Hardware reset restores default contents, returning to asynchronous access.
module brcr_config import brcr_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Command side
    input wire logic cfg_write,
    input wire logic [15:0] cfg_wdata,
    input wire logic algo_active,
    // Read back
    output logic [31:0] cfg_rdata,
    output logic write_ignored,
    // Decoded controls
    output brcr_ctrl_t ctrl
);

    // ************************************************
    // Register storage
    // ************************************************
    brcr_cfg_t cfg;
    brcr_cfg_t next_cfg;
    logic write_ok;

    assign write_ok = cfg_write && !algo_active;

    always_comb begin
        next_cfg = cfg;
        if (write_ok) begin
            next_cfg = brcr_cfg_t'(cfg_wdata);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cfg <= brcr_cfg_t'(`BRCR_RESET_VALUE);
        end else begin
            cfg <= next_cfg;
        end
    end

    // ************************************************
    // Refused write flag
    // ************************************************
    // One-cycle pulse so the host can tell a dropped write from a slow one
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            write_ignored <= 1'b0;
        end else begin
            write_ignored <= cfg_write && algo_active;
        end
    end

    // ************************************************
    // Read back
    // ************************************************
    // Built from next_cfg so read data never lags the stored value
    // upper lines read zero
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cfg_rdata <= {`BRCR_UPPER_ZERO, 16'(`BRCR_RESET_VALUE)};
        end else begin
            cfg_rdata <= {`BRCR_UPPER_ZERO, 16'(next_cfg)};
        end
    end

    // ************************************************
    // Decoding
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl <= '{sync_burst_en: 1'b0, auto_sleep_en: 1'b1, initial_delay_clks: 4'h9,
                      data_hold_clks: 2'h1, end_early: 1'b0, linear_order: 1'b1, rising_edge: 1'b1};
        end else begin
            ctrl.sync_burst_en <= !next_cfg.read_type_select;
            ctrl.auto_sleep_en <= !next_cfg.auto_sleep_off;
            // delay decode; undefined codes clamp to the longest safe delay
            if (next_cfg.initial_delay_field <= `BRCR_DELAY_MAX_CODE) begin
                ctrl.initial_delay_clks <= 4'(next_cfg.initial_delay_field + `BRCR_DELAY_BASE);
            end else begin
                ctrl.initial_delay_clks <= 4'(`BRCR_DELAY_MAX_CODE + `BRCR_DELAY_BASE);
            end
            ctrl.data_hold_clks <= 2'h1;
            ctrl.end_early <= next_cfg.end_indicator_timing;
            ctrl.linear_order <= 1'b1;
            ctrl.rising_edge <= 1'b1;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    property p_write_blocked;
        @(posedge mclk) disable iff (!resetn) (cfg_write && algo_active) |=> $stable(cfg);
    endproperty
    a_write_blocked: assert property (p_write_blocked) else $error("write taken while busy");

    property p_write_taken;
        @(posedge mclk) disable iff (!resetn) (cfg_write && !algo_active) |=> (16'(cfg) == $past(cfg_wdata));
    endproperty
    a_write_taken: assert property (p_write_taken) else $error("write not stored");

    property p_upper_zero;
        @(posedge mclk) disable iff (!resetn) cfg_rdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper lines not zero");

    property p_readback;
        @(posedge mclk) disable iff (!resetn) cfg_rdata[15:0] == 16'(cfg);
    endproperty
    a_readback: assert property (p_readback) else $error("read back mismatch");

    property p_reset_default;
        @(posedge mclk) !resetn |=> (16'(cfg) == 16'h9cc4 && !ctrl.sync_burst_en);
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("reset default wrong");

    property p_read_type;
        @(posedge mclk) disable iff (!resetn) ##1 ctrl.sync_burst_en == !cfg.read_type_select;
    endproperty
    a_read_type: assert property (p_read_type) else $error("read type decode wrong");

    property p_sleep;
        @(posedge mclk) disable iff (!resetn) ##1 ctrl.auto_sleep_en == !cfg.auto_sleep_off;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep decode wrong");

    property p_delay;
        @(posedge mclk) disable iff (!resetn) (write_ok && cfg_wdata[13:10] == 4'h3) |=> ctrl.initial_delay_clks == 4'h5;
    endproperty
    a_delay: assert property (p_delay) else $error("delay decode wrong");

    property p_end_timing;
        @(posedge mclk) disable iff (!resetn) ##1 ctrl.end_early == cfg.end_indicator_timing;
    endproperty
    a_end_timing: assert property (p_end_timing) else $error("end timing decode wrong");

    property p_fixed;
        @(posedge mclk) disable iff (!resetn) ctrl.data_hold_clks == 2'h1 && ctrl.linear_order && ctrl.rising_edge;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed fields wrong");

    // Reserved hold code must still decode to one clock
    property p_hold;
        @(posedge mclk) disable iff (!resetn) ctrl.data_hold_clks == 2'h1;
    endproperty
    a_hold: assert property (p_hold) else $error("data hold decode wrong");

    property p_linear;
        @(posedge mclk) disable iff (!resetn) ctrl.linear_order;
    endproperty
    a_linear: assert property (p_linear) else $error("burst order decode wrong");

    property p_edge;
        @(posedge mclk) disable iff (!resetn) ctrl.rising_edge;
    endproperty
    a_edge: assert property (p_edge) else $error("clock edge decode wrong");

    property p_ignored_pulse;
        @(posedge mclk) disable iff (!resetn) (cfg_write && algo_active) |=> write_ignored;
    endproperty
    a_ignored_pulse: assert property (p_ignored_pulse) else $error("refused write not flagged");

    property p_ignored_quiet;
        @(posedge mclk) disable iff (!resetn) !(cfg_write && algo_active) |=> !write_ignored;
    endproperty
    a_ignored_quiet: assert property (p_ignored_quiet) else $error("refused flag without cause");

    // Undefined codes must never shorten the delay below the longest one
    property p_delay_clamp;
        @(posedge mclk) disable iff (!resetn) (write_ok && cfg_wdata[13]) |=> ctrl.initial_delay_clks == 4'h9;
    endproperty
    a_delay_clamp: assert property (p_delay_clamp) else $error("delay clamp wrong");

    property p_delay_range;
        @(posedge mclk) disable iff (!resetn) ctrl.initial_delay_clks >= 4'h2 && ctrl.initial_delay_clks <= 4'h9;
    endproperty
    a_delay_range: assert property (p_delay_range) else $error("delay out of range");

    property p_rdata_reset;
        @(posedge mclk) !resetn |=> cfg_rdata == 32'h00009cc4 && !write_ignored;
    endproperty
    a_rdata_reset: assert property (p_rdata_reset) else $error("read back after reset wrong");

    c_sync: cover property (@(posedge mclk) disable iff (!resetn) write_ok && !cfg_wdata[15]);
    c_ignored: cover property (@(posedge mclk) disable iff (!resetn) cfg_write && algo_active);
    c_early: cover property (@(posedge mclk) disable iff (!resetn) ctrl.end_early);
    c_reset_back: cover property (@(posedge mclk) !resetn ##1 resetn);

endmodule : brcr_config

// ---- tb/brcr_host.sv ----
// Host model issuing configuration writes
`timescale 1ns/1ps
module brcr_host (
    // Clock
    input wire logic mclk,
    // Command side
    output logic cfg_write,
    output logic [15:0] cfg_wdata,
    output logic algo_active
);
    initial begin
        cfg_write = 1'b0;
        cfg_wdata = 16'h0000;
        algo_active = 1'b0;
    end
    task automatic wr(input logic [15:0] d, input logic busy);
        @(negedge mclk);
        cfg_write = 1'b1;
        cfg_wdata = d;
        algo_active = busy;
        @(negedge mclk);
        // Released lines flip so stale values never pass
        cfg_write = 1'b0;
        cfg_wdata = ~d;
        algo_active = ~busy;
    endtask : wr
endmodule : brcr_host

// ---- tb/tb_top.sv ----
// Self-checking bench for the read configuration register
`timescale 1ns/1ps
module tb_top;
    import brcr_pkg::*;
    typedef struct packed {logic [31:0] rd; brcr_ctrl_t c; logic ign;} brcr_note_t;
    logic mclk, resetn, cfg_write, algo_active, write_ignored;
    logic [15:0] cfg_wdata, reg_model;
    logic [31:0] cfg_rdata;
    brcr_ctrl_t ctrl;
    brcr_note_t q[$];
    brcr_note_t n;
    int err_count = 0;
    int n_compared = 0;
    event chk;
    brcr_config DUT (.mclk(mclk), .resetn(resetn), .cfg_write(cfg_write), .cfg_wdata(cfg_wdata),
        .algo_active(algo_active), .cfg_rdata(cfg_rdata), .write_ignored(write_ignored), .ctrl(ctrl));
    brcr_host host (.mclk(mclk), .cfg_write(cfg_write), .cfg_wdata(cfg_wdata), .algo_active(algo_active));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // ****************
    // Expected values
    // ****************
    function automatic brcr_ctrl_t dec(input logic [15:0] v);
        brcr_ctrl_t c;
        c.sync_burst_en = ~v[15];
        c.auto_sleep_en = ~v[14];
        // Codes above seven clamp to the longest delay
        c.initial_delay_clks = v[13] ? 4'h9 : v[13:10] + 4'h2;
        c.data_hold_clks = 2'h1;
        c.end_early = v[8];
        c.linear_order = 1'b1;
        c.rising_edge = 1'b1;
        return c;
    endfunction : dec
    task automatic note(input logic ign);
        q.push_back({16'h0000, reg_model, dec(reg_model), ign});
        -> chk;
    endtask : note
    task automatic wr(input logic [15:0] d, input logic busy);
        host.wr(d, busy);
        if (!busy) begin
            reg_model = d;
        end
        note(busy);
    endtask : wr
    task automatic results;
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    // ****************
    // Output monitor
    // ****************
    always @(chk) begin
        n = q.pop_front();
        n_compared++;
        if ({cfg_rdata, ctrl, write_ignored} !== n) begin
            err_count++;
            $display("mismatch readback exp %h got %h", n, {cfg_rdata, ctrl, write_ignored});
        end
    end
    // ****************
    // Stimulus
    // ****************
    initial begin
        resetn = 1'b0;
        reg_model = 16'h9cc4;
        void'($urandom(32'h45a8d314));
        repeat (12) @(negedge mclk);
        note(1'b0);
        resetn = 1'b1;
        for (int i = 0; i < 16; i++) begin
            wr({2'b00, i[3:0], 10'h1c4}, 1'b0);
        end
        repeat (40) wr(16'($urandom), $urandom_range(3) == 0);
        @(negedge mclk);
        resetn = 1'b0;
        @(negedge mclk);
        reg_model = 16'h9cc4;
        note(1'b0);
        resetn = 1'b1;
        wr(16'h1cc4, 1'b0);
        wr(16'h0000, 1'b1);
        @(negedge mclk);
        results();
    end
    initial begin
        #1000000;
        err_count++;
        results();
    end
endmodule : tb_top
